//--- pkg/mac_filter_defs.svh
/*
  offsets, field positions, reset values and eeprom locations of the filter.
  assumes a 32-bit wishbone slave decoding word indices from adr[7:2].
*/
`ifndef MAC_FILTER_DEFS_SVH
`define MAC_FILTER_DEFS_SVH

// ----------------------------------------------------------------------
// register word indices
// ----------------------------------------------------------------------
`define IDX_ADDR_HIGH 6'h02
`define IDX_ADDR_LOW 6'h03
`define IDX_HASH_UPPER 6'h04
`define IDX_HASH_LOWER 6'h05
`define IDX_FILTER_CTRL 6'h0a
`define IDX_FILTER_STAT 6'h0b

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_ADDR_HIGH 16'hffff
`define RST_ADDR_LOW 32'h0fffffff
`define RST_HASH 32'h00000000

// ----------------------------------------------------------------------
// fields
// ----------------------------------------------------------------------
`define CTRL_PASS_ALL 0
`define STAT_INIT_DONE 0
`define STAT_LAST_ACCEPT 1
`define STAT_LAST_MATCH 2

// ----------------------------------------------------------------------
// eeprom locations and frame constants
// ----------------------------------------------------------------------
`define EE_LOC_1 8'h01
`define EE_LOC_2 8'h02
`define EE_LOC_3 8'h03
`define EE_LOC_4 8'h04
`define EE_LOC_5 8'h05
`define EE_LOC_6 8'h06
`define DEST_BYTES 3'd6
`define CRC_INIT 32'hffffffff
`define CRC_POLY 32'h04c11db7

`endif

//--- pkg/mac_filter_pkg.sv
/*
  state types of the address and hash filter and of its crc engine.
  assumes the constants of mac_filter_defs.svh.
*/
package mac_filter_pkg;

  // --------------------------------------------------------------------
  // filter state
  // --------------------------------------------------------------------
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [15:0] addr_high;
    logic [31:0] addr_low;
    logic [31:0] hash_upper;
    logic [31:0] hash_lower;
    logic pass_all;
    logic init_done;
    logic [2:0] byte_cnt;
    logic [47:0] dest;
    logic pending;
    logic valid;
    logic accept;
    logic multicast;
    logic match;
    logic [5:0] index;
  } filter_state_t;

  // --------------------------------------------------------------------
  // crc engine state
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] crc;
  } crc_state_t;

endpackage

//--- pkg/hash_if.sv
/*
  byte feed from the filter to the crc engine and hash index back.
  assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
interface hash_if;
  logic clear;
  logic load;
  logic [7:0] data;
  logic [5:0] index;
  modport client (output clear, output load, output data, input index);
  modport engine (input clear, input load, input data, output index);
endinterface

//--- hw/crc_hash_unit.sv
/*
  running crc-32 over destination address bytes, lsb of each byte first.
  assumes clear comes at least one cycle before the first load.
*/
`timescale 1ns/1ns
`include "mac_filter_defs.svh"
module crc_hash_unit (
  input wire logic clk_i,
  input wire logic rst_i,
  hash_if.engine hash
);
  import mac_filter_pkg::*;

  crc_state_t s;
  crc_state_t next_s;

  // ----------------------------------------------------------------------
  // crc update
  // ----------------------------------------------------------------------
  always_comb begin
    logic fb;
    fb = 1'b0;
    next_s = s;
    if (hash.clear) begin
      next_s.crc = `CRC_INIT;
    end else if (hash.load) begin
      for (int i = 0; i < 8; i++) begin
        fb = next_s.crc[31] ^ hash.data[i];
        next_s.crc = {next_s.crc[30:0], 1'b0} ^ (fb ? `CRC_POLY : 32'h00000000);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s.crc <= `CRC_INIT;
    end else begin
      s <= next_s;
    end
  end

  // top six bits form the table index
  assign hash.index = s.crc[31:26];

  property p_crc_clear;
    @(posedge clk_i) disable iff (rst_i) hash.clear |=> s.crc == 32'hffffffff;
  endproperty
  a_crc_clear: assert property (p_crc_clear) else $error("crc not preset");

endmodule // crc_hash_unit

//--- hw/mac_address_hash_filter.sv
/*
  station address and multicast hash filter with wishbone registers.
  assumes eeprom loader and receive path run on clk_i; frame start
  pulses at least one cycle before the first destination byte.
*/
// Local design decision: register access over Wishbone.
`timescale 1ns/1ns
`include "mac_filter_defs.svh"
module mac_address_hash_filter (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ee_load_i,
  input wire logic [7:0] ee_loc_i,
  input wire logic [7:0] ee_byte_i,
  input wire logic init_done_i,
  input wire logic rx_frame_start_i,
  input wire logic rx_byte_valid_i,
  input wire logic [7:0] rx_byte_i,
  output logic filt_valid_o,
  output logic filt_accept_o,
  output logic filt_multicast_o,
  output logic filt_match_o,
  output logic [5:0] hash_index_o
);
  import mac_filter_pkg::*;

  filter_state_t s;
  filter_state_t next_s;
  logic req;
  logic [5:0] idx;
  logic take_byte;
  logic [47:0] station;
  logic [63:0] hash_table;
  logic [47:0] dest_now;
  logic [31:0] high_merged;

  hash_if hash_bus ();

  crc_hash_unit u_crc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .hash(hash_bus)
  );

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] wr,
    input logic [3:0] sel
  );
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = wr[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] read_word(
    input filter_state_t st,
    input logic [5:0] i
  );
    logic [31:0] r;
    r = 32'h00000000;
    unique case (i)
      `IDX_ADDR_HIGH: r = {16'h0000, st.addr_high};
      `IDX_ADDR_LOW: r = st.addr_low;
      `IDX_HASH_UPPER: r = st.hash_upper;
      `IDX_HASH_LOWER: r = st.hash_lower;
      `IDX_FILTER_CTRL: r[`CTRL_PASS_ALL] = st.pass_all;
      `IDX_FILTER_STAT: begin
        r[`STAT_INIT_DONE] = st.init_done;
        r[`STAT_LAST_ACCEPT] = st.accept;
        r[`STAT_LAST_MATCH] = st.match;
      end
      default: r = 32'h00000000;
    endcase
    return r;
  endfunction

  assign req = wb_cyc_i && wb_stb_i;
  assign idx = wb_adr_i[7:2];
  assign take_byte = rx_byte_valid_i && (s.byte_cnt < `DEST_BYTES);
  assign station = {s.addr_high, s.addr_low};
  assign hash_table = {s.hash_upper, s.hash_lower};
  assign dest_now = s.dest;
  assign high_merged = merge({16'h0000, s.addr_high}, wb_dat_i, wb_sel_i);

  // ----------------------------------------------------------------------
  // crc feed
  // ----------------------------------------------------------------------
  assign hash_bus.clear = rx_frame_start_i;
  assign hash_bus.load = take_byte && !rx_frame_start_i;
  assign hash_bus.data = rx_byte_i;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.ack = 1'b0;
    next_s.valid = 1'b0;

    // one wait state; unmapped words read zero and still ack
    if (req && !s.ack) begin
      next_s.ack = 1'b1;
      next_s.rdata = read_word(s, idx);
    end

    // write lands on the edge where the master sees ack
    if (req && s.ack && wb_we_i) begin
      unique case (idx)
        `IDX_ADDR_HIGH: begin
          if (s.init_done) begin
            next_s.addr_high = high_merged[15:0];
          end
        end
        `IDX_ADDR_LOW: begin
          if (s.init_done) begin
            next_s.addr_low = merge(s.addr_low, wb_dat_i, wb_sel_i);
          end
        end
        `IDX_HASH_UPPER: next_s.hash_upper = merge(s.hash_upper, wb_dat_i, wb_sel_i);
        `IDX_HASH_LOWER: next_s.hash_lower = merge(s.hash_lower, wb_dat_i, wb_sel_i);
        `IDX_FILTER_CTRL: begin
          if (wb_sel_i[0]) begin
            next_s.pass_all = wb_dat_i[`CTRL_PASS_ALL];
          end
        end
        default: begin
        end
      endcase
    end

    // power-on load; loader owns the address until init completes
    if (ee_load_i && !s.init_done) begin
      unique case (ee_loc_i)
        `EE_LOC_1: next_s.addr_low[7:0] = ee_byte_i;
        `EE_LOC_2: next_s.addr_low[15:8] = ee_byte_i;
        `EE_LOC_3: next_s.addr_low[23:16] = ee_byte_i;
        `EE_LOC_4: next_s.addr_low[31:24] = ee_byte_i;
        `EE_LOC_5: next_s.addr_high[7:0] = ee_byte_i;
        `EE_LOC_6: next_s.addr_high[15:8] = ee_byte_i;
        default: begin
        end
      endcase
    end

    if (init_done_i) begin
      next_s.init_done = 1'b1;
    end

    // destination bytes stored in wire order
    if (rx_frame_start_i) begin
      next_s.byte_cnt = 3'd0;
      next_s.pending = 1'b0;
    end else if (take_byte) begin
      next_s.dest[s.byte_cnt*8 +: 8] = rx_byte_i;
      next_s.byte_cnt = s.byte_cnt + 3'd1;
      if (s.byte_cnt == `DEST_BYTES - 3'd1) begin
        next_s.pending = 1'b1;
      end
    end

    // decision one cycle after the sixth byte, once crc has settled
    if (s.pending) begin
      next_s.pending = 1'b0;
      next_s.valid = 1'b1;
      next_s.index = hash_bus.index;
      next_s.multicast = s.dest[0];
      next_s.match = (s.dest == station);
      if (!s.dest[0]) begin
        next_s.accept = (s.dest == station);
      end else if (&s.dest) begin
        next_s.accept = 1'b1;
      end else if (s.pass_all) begin
        next_s.accept = 1'b1;
      end else begin
        next_s.accept = hash_table[hash_bus.index];
      end
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s.ack <= 1'b0;
      s.rdata <= 32'h00000000;
      s.addr_high <= `RST_ADDR_HIGH;
      s.addr_low <= `RST_ADDR_LOW;
      s.hash_upper <= `RST_HASH;
      s.hash_lower <= `RST_HASH;
      s.pass_all <= 1'b0;
      s.init_done <= 1'b0;
      s.byte_cnt <= `DEST_BYTES;
      s.dest <= 48'h000000000000;
      s.pending <= 1'b0;
      s.valid <= 1'b0;
      s.accept <= 1'b0;
      s.multicast <= 1'b0;
      s.match <= 1'b0;
      s.index <= 6'h00;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign wb_dat_o = s.rdata;
  assign wb_ack_o = s.ack;
  assign filt_valid_o = s.valid;
  assign filt_accept_o = s.accept;
  assign filt_multicast_o = s.multicast;
  assign filt_match_o = s.match;
  assign hash_index_o = s.index;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_high_reserved;
    @(posedge clk_i) disable iff (rst_i)
      (req && !s.ack && !wb_we_i && idx == `IDX_ADDR_HIGH)
        |=> wb_ack_o && wb_dat_o[31:16] == 16'h0000 && wb_dat_o[15:0] == $past(s.addr_high);
  endproperty
  a_high_reserved: assert property (p_high_reserved) else $error("high read wrong");

  property p_ee_high;
    @(posedge clk_i) disable iff (rst_i)
      (ee_load_i && !s.init_done && ee_loc_i == 8'h06)
        |=> s.addr_high[15:8] == $past(ee_byte_i);
  endproperty
  a_ee_high: assert property (p_ee_high) else $error("eeprom high byte lost");

  property p_ee_low;
    @(posedge clk_i) disable iff (rst_i)
      (ee_load_i && !s.init_done && ee_loc_i == 8'h01)
        |=> s.addr_low[7:0] == $past(ee_byte_i) && $stable(s.addr_low[31:8]);
  endproperty
  a_ee_low: assert property (p_ee_low) else $error("eeprom low byte lost");

  property p_unicast_match;
    @(posedge clk_i) disable iff (rst_i)
      (filt_valid_o && !filt_multicast_o)
        |-> filt_accept_o == ($past(station) == $past(dest_now));
  endproperty
  a_unicast_match: assert property (p_unicast_match) else $error("unicast decision");

  property p_reset_values;
    @(posedge clk_i) disable iff (rst_i)
      $past(rst_i) |-> s.addr_high == 16'hffff && s.addr_low == 32'h0fffffff;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("address reset");

  property p_early_write;
    @(posedge clk_i) disable iff (rst_i)
      (req && s.ack && wb_we_i && !s.init_done && !ee_load_i) |=> $stable(station);
  endproperty
  a_early_write: assert property (p_early_write) else $error("early write landed");

  property p_hash_bit;
    @(posedge clk_i) disable iff (rst_i)
      (filt_valid_o && filt_multicast_o && !$past(s.pass_all) && !(&$past(dest_now)))
        |-> filt_accept_o == $past(hash_table[hash_bus.index]);
  endproperty
  a_hash_bit: assert property (p_hash_bit) else $error("hash decision");

  property p_pass_all;
    @(posedge clk_i) disable iff (rst_i)
      (filt_valid_o && filt_multicast_o && $past(s.pass_all)) |-> filt_accept_o;
  endproperty
  a_pass_all: assert property (p_pass_all) else $error("multicast dropped");

  property p_hash_reset;
    @(posedge clk_i) disable iff (rst_i)
      $past(rst_i) |-> hash_table == 64'h0000000000000000;
  endproperty
  a_hash_reset: assert property (p_hash_reset) else $error("hash reset");

  property p_decision_time;
    @(posedge clk_i) disable iff (rst_i)
      (take_byte && !rx_frame_start_i && s.byte_cnt == 3'd5)
        |=> ##1 filt_valid_o && hash_index_o == $past(hash_bus.index);
  endproperty
  a_decision_time: assert property (p_decision_time) else $error("decision late");

  property p_low_read;
    @(posedge clk_i) disable iff (rst_i)
      (req && !s.ack && !wb_we_i && idx == `IDX_ADDR_LOW)
        |=> wb_dat_o == $past(s.addr_low);
  endproperty
  a_low_read: assert property (p_low_read) else $error("low read wrong");

  property p_ee_mid;
    @(posedge clk_i) disable iff (rst_i)
      (ee_load_i && !s.init_done && ee_loc_i == `EE_LOC_5)
        |=> s.addr_high[7:0] == $past(ee_byte_i) && $stable(s.addr_high[15:8]);
  endproperty
  a_ee_mid: assert property (p_ee_mid) else $error("eeprom fifth byte lost");

  property p_ee_top;
    @(posedge clk_i) disable iff (rst_i)
      (ee_load_i && !s.init_done && ee_loc_i == `EE_LOC_4)
        |=> s.addr_low[31:24] == $past(ee_byte_i) && $stable(s.addr_low[23:0]);
  endproperty
  a_ee_top: assert property (p_ee_top) else $error("eeprom fourth byte lost");

  property p_host_high;
    @(posedge clk_i) disable iff (rst_i)
      (req && s.ack && wb_we_i && s.init_done && idx == `IDX_ADDR_HIGH && wb_sel_i == 4'hf)
        |=> s.addr_high == $past(wb_dat_i[15:0]);
  endproperty
  a_host_high: assert property (p_host_high) else $error("host write lost");

  property p_hash_write;
    @(posedge clk_i) disable iff (rst_i)
      (req && s.ack && wb_we_i && idx == `IDX_HASH_UPPER && wb_sel_i == 4'hf)
        |=> s.hash_upper == $past(wb_dat_i);
  endproperty
  a_hash_write: assert property (p_hash_write) else $error("hash write lost");

  // ack must drop the cycle after it rises; a request held past ack is acked again
  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");

endmodule // mac_address_hash_filter

//--- sim/mac_filter_partner.sv
/*
  eeprom loader and receive path model driving the filter's side inputs.
  assumes one clock, clk_i, shared with the filter; tasks called by the bench.
*/
`timescale 1ns/1ns
module mac_filter_partner (
  input wire logic clk_i,
  output logic ee_load_o,
  output logic [7:0] ee_loc_o,
  output logic [7:0] ee_byte_o,
  output logic init_done_o,
  output logic rx_frame_start_o,
  output logic rx_byte_valid_o,
  output logic [7:0] rx_byte_o
);
  initial begin
    ee_load_o = 1'b0;
    ee_loc_o = 8'h00;
    ee_byte_o = 8'h00;
    init_done_o = 1'b0;
    rx_frame_start_o = 1'b0;
    rx_byte_valid_o = 1'b0;
    rx_byte_o = 8'h00;
  end
  // ----------------------------------------------------------------------
  // loader
  // ----------------------------------------------------------------------
  task automatic ee_write(input logic [7:0] loc, input logic [7:0] val);
    @(posedge clk_i);
    ee_load_o <= 1'b1;
    ee_loc_o <= loc;
    ee_byte_o <= val;
    @(posedge clk_i);
    ee_load_o <= 1'b0;
    // stale lines must not look like a valid repeat
    ee_loc_o <= ~loc;
    ee_byte_o <= ~val;
  endtask
  task automatic finish_init;
    @(posedge clk_i);
    init_done_o <= 1'b1;
  endtask
  // ----------------------------------------------------------------------
  // receive path
  // ----------------------------------------------------------------------
  task automatic send_dest(input logic [47:0] dest);
    @(posedge clk_i);
    rx_frame_start_o <= 1'b1;
    @(posedge clk_i);
    rx_frame_start_o <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      @(posedge clk_i);
      rx_byte_valid_o <= 1'b1;
      rx_byte_o <= dest[8*k +: 8];
    end
    @(posedge clk_i);
    rx_byte_valid_o <= 1'b0;
    rx_byte_o <= ~dest[47:40];
  endtask
endmodule // mac_filter_partner

//--- sim/mac_address_hash_filter_tb.sv
/*
  self-checking bench: wishbone register tests, eeprom load, frame decisions.
  assumes the filter and the partner model share clk_i at 100 mhz.
*/
`timescale 1ns/1ns
`include "mac_filter_defs.svh"
module mac_address_hash_filter_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rd;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, filt_valid_o, filt_accept_o, filt_multicast_o, filt_match_o;
  logic [5:0] hash_index_o, idx;
  logic ee_load, init_done, fstart, bvalid;
  logic [7:0] ee_loc, ee_byte, rx_byte;
  logic [7:0] ee [1:6] = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h9a, 8'hbc};
  logic [47:0] sta, mc;
  int n_errors = 0, samples_checked = 0, cycles = 0;
  always #5 clk_i = ~clk_i;
  mac_address_hash_filter uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .ee_load_i(ee_load), .ee_loc_i(ee_loc), .ee_byte_i(ee_byte),
    .init_done_i(init_done), .rx_frame_start_i(fstart), .rx_byte_valid_i(bvalid),
    .rx_byte_i(rx_byte), .filt_valid_o(filt_valid_o), .filt_accept_o(filt_accept_o),
    .filt_multicast_o(filt_multicast_o), .filt_match_o(filt_match_o),
    .hash_index_o(hash_index_o));
  mac_filter_partner far (.clk_i(clk_i), .ee_load_o(ee_load), .ee_loc_o(ee_loc),
    .ee_byte_o(ee_byte), .init_done_o(init_done), .rx_frame_start_o(fstart),
    .rx_byte_valid_o(bvalid), .rx_byte_o(rx_byte));
  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_flag(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask
  // one classic cycle; no fixed latency assumed, only the global timeout ends it
  task automatic wb(input logic w, input logic [5:0] index, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {index, 2'b00};
    sel <= 4'hf;
    wdat <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd_chk(input string what, input logic [5:0] index, input logic [31:0] exp);
    wb(1'b0, index, 32'h0);
    chk_reg(what, exp, rd);
  endtask
  task automatic frame(input logic [47:0] dest);
    far.send_dest(dest);
    while (filt_valid_o !== 1'b1) @(posedge clk_i);
  endtask
  // reference index: lsb of each byte first, top six bits of the crc
  function automatic logic [5:0] crc_idx(input logic [47:0] d);
    logic [31:0] c;
    logic fb;
    c = `CRC_INIT;
    for (int i = 0; i < 48; i++) begin
      fb = c[31] ^ d[i];
      c = {c[30:0], 1'b0};
      if (fb) c = c ^ `CRC_POLY;
    end
    return c[31:26];
  endfunction
  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("addr_high", `IDX_ADDR_HIGH, 32'h0000ffff);
    rd_chk("addr_low", `IDX_ADDR_LOW, 32'h0fffffff);
    rd_chk("hash_upper", `IDX_HASH_UPPER, 32'h0);
    rd_chk("hash_lower", `IDX_HASH_LOWER, 32'h0);
    rd_chk("unmapped", 6'h0f, 32'h0);
    $display("test reset values done");
    for (int k = 6; k >= 1; k--) far.ee_write(k[7:0], ee[k]);
    far.ee_write(8'h07, 8'h55);
    rd_chk("addr_low", `IDX_ADDR_LOW, {ee[4], ee[3], ee[2], ee[1]});
    rd_chk("addr_high", `IDX_ADDR_HIGH, {16'h0, ee[6], ee[5]});
    wb(1'b1, `IDX_ADDR_LOW, 32'h0);
    rd_chk("addr_low", `IDX_ADDR_LOW, {ee[4], ee[3], ee[2], ee[1]});
    $display("test eeprom load done");
    far.finish_init();
    far.ee_write(8'h01, 8'h00);
    wb(1'b1, `IDX_ADDR_HIGH, 32'hffffffff);
    rd_chk("addr_high", `IDX_ADDR_HIGH, 32'h0000ffff);
    wb(1'b1, `IDX_ADDR_HIGH, {16'h0, ee[6], ee[5]});
    rd_chk("addr_low", `IDX_ADDR_LOW, {ee[4], ee[3], ee[2], ee[1]});
    wb(1'b1, `IDX_HASH_UPPER, 32'ha5a5a5a5);
    rd_chk("hash_upper", `IDX_HASH_UPPER, 32'ha5a5a5a5);
    $display("test host writes done");
    sta = {ee[6], ee[5], ee[4], ee[3], ee[2], ee[1]};
    frame(sta);
    chk_flag("match", 1'b1, filt_match_o);
    chk_flag("accept", 1'b1, filt_accept_o);
    rd_chk("status", `IDX_FILTER_STAT, 32'h7);
    frame(sta ^ 48'h000000000100);
    chk_flag("match", 1'b0, filt_match_o);
    chk_flag("accept", 1'b0, filt_accept_o);
    rd_chk("status", `IDX_FILTER_STAT, 32'h1);
    $display("test station match done");
    mc = 48'h665544332201;
    idx = crc_idx(mc);
    wb(1'b1, `IDX_HASH_UPPER, idx[5] ? (32'h1 << idx[4:0]) : 32'h0);
    wb(1'b1, `IDX_HASH_LOWER, idx[5] ? 32'h0 : (32'h1 << idx[4:0]));
    frame(mc);
    chk_reg("index", {26'h0, idx}, {26'h0, hash_index_o});
    chk_flag("multicast", 1'b1, filt_multicast_o);
    chk_flag("accept", 1'b1, filt_accept_o);
    wb(1'b1, `IDX_HASH_UPPER, idx[5] ? ~(32'h1 << idx[4:0]) : 32'hffffffff);
    wb(1'b1, `IDX_HASH_LOWER, idx[5] ? 32'hffffffff : ~(32'h1 << idx[4:0]));
    frame(mc);
    chk_flag("accept", 1'b0, filt_accept_o);
    wb(1'b1, `IDX_FILTER_CTRL, 32'h1);
    rd_chk("ctrl", `IDX_FILTER_CTRL, 32'h1);
    frame(mc);
    chk_flag("accept", 1'b1, filt_accept_o);
    wb(1'b1, `IDX_FILTER_CTRL, 32'h0);
    frame(mc);
    chk_flag("accept", 1'b0, filt_accept_o);
    // empty table: broadcast must pass on its own
    wb(1'b1, `IDX_HASH_UPPER, 32'h0);
    wb(1'b1, `IDX_HASH_LOWER, 32'h0);
    frame(48'hffffffffffff);
    chk_flag("bc_multicast", 1'b1, filt_multicast_o);
    chk_flag("bc_accept", 1'b1, filt_accept_o);
    $display("test multicast hash done");
    stop_test();
  end
endmodule // mac_address_hash_filter_tb
